// *** common/spd_map.vh ***
// Purpose: shared constants of the serial 101 pattern detector
// Assumes: included by bare name from the level engine and detector design files
// Notes: definitions only
`ifndef SPD_MAP_VH
`define SPD_MAP_VH

// binary state codes, high bit first
`define SPD_ST_IDLE 2'h0
`define SPD_ST_SEEN1 2'h1
`define SPD_ST_SEEN10 2'h2
`define SPD_ST_MATCHED 2'h3
`define SPD_STATE_RESET 2'h0

// state bit positions
`define SPD_BIT_HIGH 1
`define SPD_BIT_LOW 0

// one-hot positions of the level state engine
`define SPD_OH_IDLE 0
`define SPD_OH_SEEN1 1
`define SPD_OH_SEEN10 2
`define SPD_OH_MATCHED 3
`define SPD_OH_RESET 4'h1

// transition indices of the level state engine
`define SPD_TR_IDLE_SEEN1 0
`define SPD_TR_SEEN1_SEEN10 1
`define SPD_TR_SEEN10_IDLE 2
`define SPD_TR_SEEN10_MATCHED 3
`define SPD_TR_MATCHED_IDLE 4
`define SPD_TR_COUNT 5

// match counter
`define SPD_COUNT_WIDTH 16

`endif

// *** hdl/spd_trans_ff.v ***
// Purpose: one transition qualifier of the level state engine
// Assumes: sample_en_in is a one-cycle pulse at each serial clock rising edge
// Notes: held cleared while its source state is inactive
`timescale 1ns/10ps
module spd_trans_ff #(
  parameter TAKE_ONE = 1'b1
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire clear_in,
  input wire src_active_in,
  input wire sample_en_in,
  input wire bit_in,
  output wire fire_out
);
  reg fire_reg;

  assign fire_out = fire_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fire_reg <= 1'b0;
    end else if (clear_in || !src_active_in) begin
      fire_reg <= 1'b0;
    end else if (sample_en_in && (bit_in == TAKE_ONE)) begin
      fire_reg <= 1'b1;
    end
  end
endmodule // spd_trans_ff

// *** hdl/spd_level_state_engine.v ***
// Purpose: one-hot state engine that follows level transition inputs
// Assumes: at most one transition input of the active state is high
// Notes: an illegal one-hot value falls back to idle
`timescale 1ns/10ps
`include "spd_map.vh"
module spd_level_state_engine (
  input wire clk_in,
  input wire rst_n_in,
  input wire clear_in,
  input wire [`SPD_TR_COUNT-1:0] fire_in,
  output wire [3:0] active_out
);
  reg [3:0] active_reg;
  reg [3:0] active_next;
  // one-hot state codes
  localparam [3:0] OH_IDLE = 4'h1;
  localparam [3:0] OH_SEEN1 = 4'h2;
  localparam [3:0] OH_SEEN10 = 4'h4;
  localparam [3:0] OH_MATCHED = 4'h8;

  assign active_out = active_reg;

  always @* begin
    active_next = active_reg;
    case (active_reg)
      OH_IDLE: begin
        if (fire_in[`SPD_TR_IDLE_SEEN1]) begin
          active_next = OH_SEEN1;
        end
      end
      OH_SEEN1: begin
        if (fire_in[`SPD_TR_SEEN1_SEEN10]) begin
          active_next = OH_SEEN10;
        end
      end
      OH_SEEN10: begin
        if (fire_in[`SPD_TR_SEEN10_IDLE]) begin
          active_next = OH_IDLE;
        end else if (fire_in[`SPD_TR_SEEN10_MATCHED]) begin
          active_next = OH_MATCHED;
        end
      end
      OH_MATCHED: begin
        if (fire_in[`SPD_TR_MATCHED_IDLE]) begin
          active_next = OH_IDLE;
        end
      end
      default: begin
        active_next = `SPD_OH_RESET;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_reg <= `SPD_OH_RESET;
    end else if (clear_in) begin
      active_reg <= `SPD_OH_RESET;
    end else begin
      active_reg <= active_next;
    end
  end
endmodule // spd_level_state_engine

// *** hdl/spd_pattern_detector.v ***
// Purpose: Moore detector of the serial pattern 101, two implementations side by side
// Assumes: serial clock and bit arrive on pins, slower than a quarter of REF_CLK_IN
// Notes: direct two-bit machine drives MATCH_OUT, level engine cross-checks it
// How it works
// - In idle the output is low, a 0 keeps idle and a 1 moves to seen-one.
// - In seen-one a 1 keeps seen-one and a 0 moves to seen-one-zero.
// - In seen-one-zero a 0 means 100 was seen and the machine returns to idle.
// - In seen-one-zero a 1 completes 101 and enters matched, where the output is high.
// - In matched a 1 keeps matched and the first 0 returns to idle.
// - The output depends on the present state only and changes only after a sample edge or a synchronous clear.
// - Four states live in two state bits: idle 00, seen-one 01, seen-one-zero 10, matched 11.
// - The next low state bit equals the sampled bit in every state.
// - The next high state bit is set for state 01 with input 0 or high bit 1 with input 1.
// - The match output is 1 only for state code 11.
// - State updates on rising serial clock edges and the source holds the bit valid there.
// - In the engine variant a transition flop is cleared while its source state is inactive.
`timescale 1ns/10ps
`include "spd_map.vh"
module spd_pattern_detector #(
  parameter COUNT_WIDTH = `SPD_COUNT_WIDTH
) (
  input wire REF_CLK_IN,
  input wire RESET_N_IN,
  input wire SERIAL_CLK_IN,
  input wire SERIAL_BIT_IN,
  input wire SYNC_CLEAR_IN,
  output wire MATCH_OUT,
  output wire [1:0] STATE_OUT,
  output wire MATCH_START_OUT,
  output wire SAMPLE_STROBE_OUT,
  output wire [COUNT_WIDTH-1:0] MATCH_COUNT_OUT,
  output wire ENGINE_MATCH_OUT,
  output wire [1:0] ENGINE_STATE_OUT,
  output wire VARIANT_MISMATCH_OUT
);
  // binary state codes of the direct machine
  localparam [1:0] ST_IDLE = `SPD_ST_IDLE;
  localparam [1:0] ST_SEEN1 = `SPD_ST_SEEN1;
  localparam [1:0] ST_SEEN10 = `SPD_ST_SEEN10;
  localparam [1:0] ST_MATCHED = `SPD_ST_MATCHED;
  // one-hot codes of the level state engine
  localparam [3:0] OH_IDLE = 4'h1;
  localparam [3:0] OH_SEEN1 = 4'h2;
  localparam [3:0] OH_SEEN10 = 4'h4;
  localparam [3:0] OH_MATCHED = 4'h8;
  // pin synchronisers
  reg sclk_meta_reg;
  reg sclk_sync_reg;
  reg sclk_prev_reg;
  reg sbit_meta_reg;
  reg sbit_sync_reg;
  reg clear_meta_reg;
  reg clear_sync_reg;
  // direct machine
  reg state_bit_high;
  reg state_bit_low;
  reg next_state_bit_high;
  reg next_state_bit_low;
  reg match_reg;
  reg match_start_reg;
  reg strobe_reg;
  reg [COUNT_WIDTH-1:0] count_reg;
  reg [1:0] state_d1_reg;
  reg [1:0] table_next;
  // engine side
  reg [1:0] eng_code;
  reg eng_illegal;
  reg [1:0] eng_state_reg;
  reg eng_match_reg;
  reg mismatch_reg;
  wire sample_en;
  wire sample_bit;
  wire sync_clear;
  wire [1:0] state_now;
  wire [1:0] state_next;
  wire table_err;
  wire [3:0] eng_active;
  wire [`SPD_TR_COUNT-1:0] eng_fire;

  assign MATCH_OUT = match_reg;
  assign STATE_OUT = state_now;
  assign MATCH_START_OUT = match_start_reg;
  assign SAMPLE_STROBE_OUT = strobe_reg;
  assign MATCH_COUNT_OUT = count_reg;
  assign ENGINE_MATCH_OUT = eng_match_reg;
  assign ENGINE_STATE_OUT = eng_state_reg;
  assign VARIANT_MISMATCH_OUT = mismatch_reg;

  // two flops on the serial clock, serial bit and clear pins before use
  always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      sbit_meta_reg <= 1'b0;
      sbit_sync_reg <= 1'b0;
      clear_meta_reg <= 1'b0;
      clear_sync_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= SERIAL_CLK_IN;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      sbit_meta_reg <= SERIAL_BIT_IN;
      sbit_sync_reg <= sbit_meta_reg;
      clear_meta_reg <= SYNC_CLEAR_IN;
      clear_sync_reg <= clear_meta_reg;
    end
  end

  // bit and clock go through equal delays, so the bit is taken as it stood at the edge
  assign sample_en = sclk_sync_reg & ~sclk_prev_reg;
  assign sample_bit = sbit_sync_reg;
  assign sync_clear = clear_sync_reg;

  assign state_now = {state_bit_high, state_bit_low};

  always @* begin
    next_state_bit_low = sample_bit;
    next_state_bit_high = (~state_bit_high & state_bit_low & ~sample_bit) |
      (state_bit_high & sample_bit);
  end

  assign state_next = {next_state_bit_high, next_state_bit_low};

  // direct two-bit machine
  always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_bit_high <= 1'b0;
      state_bit_low <= 1'b0;
      match_reg <= 1'b0;
    end else if (sync_clear) begin
      state_bit_high <= 1'b0;
      state_bit_low <= 1'b0;
      match_reg <= 1'b0;
    end else if (sample_en) begin
      state_bit_high <= next_state_bit_high;
      state_bit_low <= next_state_bit_low;
      // output registered with the state it decodes, so it never follows the input
      match_reg <= next_state_bit_high & next_state_bit_low;
    end
  end

  // per-state transition table, held against the two equations at every sample
  // a gap between the two shows up on the mismatch flag instead of passing silently
  always @* begin
    table_next = ST_IDLE;
    case (state_now)
      ST_IDLE: begin
        table_next = sample_bit ? ST_SEEN1 : ST_IDLE;
      end
      ST_SEEN1: begin
        table_next = sample_bit ? ST_SEEN1 : ST_SEEN10;
      end
      ST_SEEN10: begin
        if (sample_bit) begin
          table_next = ST_MATCHED;
        end else begin
          table_next = ST_IDLE;
        end
      end
      ST_MATCHED: begin
        table_next = sample_bit ? ST_MATCHED : ST_IDLE;
      end
      default: begin
        table_next = ST_IDLE;
      end
    endcase
  end

  assign table_err = sample_en & (table_next != state_next);

  // event pulses and match counter
  always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      match_start_reg <= 1'b0;
      strobe_reg <= 1'b0;
      count_reg <= {COUNT_WIDTH{1'b0}};
    end else begin
      strobe_reg <= sample_en & ~sync_clear;
      match_start_reg <= 1'b0;
      if (sync_clear) begin
        count_reg <= {COUNT_WIDTH{1'b0}};
      end else if (sample_en && (state_now == `SPD_ST_SEEN10) &&
                   (state_next == `SPD_ST_MATCHED)) begin
        match_start_reg <= 1'b1;
        if (count_reg != {COUNT_WIDTH{1'b1}}) begin
          count_reg <= count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // level state engine variant with one qualifier flop per transition
  spd_trans_ff #(
    .TAKE_ONE(1'b1)
  ) u_tr_idle_seen1 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .src_active_in(eng_active[`SPD_OH_IDLE]),
    .sample_en_in(sample_en),
    .bit_in(sample_bit),
    .fire_out(eng_fire[`SPD_TR_IDLE_SEEN1])
  );

  spd_trans_ff #(
    .TAKE_ONE(1'b0)
  ) u_tr_seen1_seen10 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .src_active_in(eng_active[`SPD_OH_SEEN1]),
    .sample_en_in(sample_en),
    .bit_in(sample_bit),
    .fire_out(eng_fire[`SPD_TR_SEEN1_SEEN10])
  );

  spd_trans_ff #(
    .TAKE_ONE(1'b0)
  ) u_tr_seen10_idle (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .src_active_in(eng_active[`SPD_OH_SEEN10]),
    .sample_en_in(sample_en),
    .bit_in(sample_bit),
    .fire_out(eng_fire[`SPD_TR_SEEN10_IDLE])
  );

  spd_trans_ff #(
    .TAKE_ONE(1'b1)
  ) u_tr_seen10_matched (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .src_active_in(eng_active[`SPD_OH_SEEN10]),
    .sample_en_in(sample_en),
    .bit_in(sample_bit),
    .fire_out(eng_fire[`SPD_TR_SEEN10_MATCHED])
  );

  spd_trans_ff #(
    .TAKE_ONE(1'b0)
  ) u_tr_matched_idle (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .src_active_in(eng_active[`SPD_OH_MATCHED]),
    .sample_en_in(sample_en),
    .bit_in(sample_bit),
    .fire_out(eng_fire[`SPD_TR_MATCHED_IDLE])
  );

  spd_level_state_engine u_engine (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(sync_clear),
    .fire_in(eng_fire),
    .active_out(eng_active)
  );

  // one-hot to state code
  always @* begin
    eng_illegal = 1'b0;
    case (eng_active)
      OH_IDLE: begin
        eng_code = `SPD_ST_IDLE;
      end
      OH_SEEN1: begin
        eng_code = `SPD_ST_SEEN1;
      end
      OH_SEEN10: begin
        eng_code = `SPD_ST_SEEN10;
      end
      OH_MATCHED: begin
        eng_code = `SPD_ST_MATCHED;
      end
      default: begin
        eng_code = `SPD_ST_IDLE;
        eng_illegal = 1'b1;
      end
    endcase
  end

  // engine lags the direct machine by one cycle; compare against a delayed copy
  always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_d1_reg <= `SPD_STATE_RESET;
      eng_state_reg <= `SPD_STATE_RESET;
      eng_match_reg <= 1'b0;
      mismatch_reg <= 1'b0;
    end else begin
      // the delayed copy clears with the engine, so a clear never reads as a disagreement
      if (sync_clear) begin
        state_d1_reg <= `SPD_STATE_RESET;
      end else begin
        state_d1_reg <= state_now;
      end
      eng_state_reg <= eng_code;
      eng_match_reg <= eng_active[`SPD_OH_MATCHED];
      // a disagreement in the clear cycle still sets the flag
      if (eng_illegal || (eng_code != state_d1_reg) || table_err) begin
        mismatch_reg <= 1'b1;
      end else if (sync_clear) begin
        mismatch_reg <= 1'b0;
      end
    end
  end
endmodule // spd_pattern_detector

// *** verification/spd_checker.sv ***
// Purpose: port-level assertions for the serial 101 pattern detector
// Assumes: serial bit held 3 cycles either side of the sampled serial edge
// Notes: bound to the top module at the foot of this file
`timescale 1ns/10ps
module spd_checker #(
  parameter COUNT_WIDTH = 16
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic SERIAL_BIT_IN,
  input wire logic SYNC_CLEAR_IN,
  input wire logic MATCH_OUT,
  input wire logic [1:0] STATE_OUT,
  input wire logic MATCH_START_OUT,
  input wire logic SAMPLE_STROBE_OUT,
  input wire logic [COUNT_WIDTH-1:0] MATCH_COUNT_OUT,
  input wire logic ENGINE_MATCH_OUT,
  input wire logic [1:0] ENGINE_STATE_OUT,
  input wire logic VARIANT_MISMATCH_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_match_decode: assert property (MATCH_OUT == &STATE_OUT)
    else $error("match output differs from state code 11");
  a_low_bit_next: assert property (
    SAMPLE_STROBE_OUT |-> STATE_OUT[0] == $past(SERIAL_BIT_IN, 3))
    else $error("low state bit does not follow sampled bit");
  a_high_bit_next: assert property (SAMPLE_STROBE_OUT |-> STATE_OUT[1] ==
    (($past(STATE_OUT) == 2'h1 && !$past(SERIAL_BIT_IN, 3)) ||
    ($past(STATE_OUT[1]) && $past(SERIAL_BIT_IN, 3))))
    else $error("high state bit wrong after sample");
  a_state_on_sample: assert property (
    $changed(STATE_OUT) && STATE_OUT != 2'h0 |-> SAMPLE_STROBE_OUT)
    else $error("state moved without a sample");
  a_match_entry: assert property (
    $rose(MATCH_OUT) |-> MATCH_START_OUT && $past(STATE_OUT) == 2'h2)
    else $error("matched entered from wrong state or without start pulse");
  a_strobe_single: assert property (SAMPLE_STROBE_OUT |=> !SAMPLE_STROBE_OUT)
    else $error("sample strobe longer than one cycle");
  a_clear_idles: assert property (SYNC_CLEAR_IN [*4] |=>
    STATE_OUT == 2'h0 && MATCH_COUNT_OUT == {COUNT_WIDTH{1'b0}})
    else $error("clear did not return to idle");
  a_engine_tracks: assert property (
    !($past(SYNC_CLEAR_IN, 4) && !$past(SYNC_CLEAR_IN, 5)) |->
    ENGINE_STATE_OUT == $past(STATE_OUT, 2) && ENGINE_MATCH_OUT == &ENGINE_STATE_OUT)
    else $error("level engine disagrees with direct machine");
  a_no_mismatch: assert property (!VARIANT_MISMATCH_OUT)
    else $error("variant mismatch flag set");
endmodule // spd_checker

bind spd_pattern_detector spd_checker #(.COUNT_WIDTH(COUNT_WIDTH)) i_spd_checker (
  .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .SERIAL_BIT_IN(SERIAL_BIT_IN),
  .SYNC_CLEAR_IN(SYNC_CLEAR_IN), .MATCH_OUT(MATCH_OUT), .STATE_OUT(STATE_OUT),
  .MATCH_START_OUT(MATCH_START_OUT), .SAMPLE_STROBE_OUT(SAMPLE_STROBE_OUT),
  .MATCH_COUNT_OUT(MATCH_COUNT_OUT), .ENGINE_MATCH_OUT(ENGINE_MATCH_OUT),
  .ENGINE_STATE_OUT(ENGINE_STATE_OUT), .VARIANT_MISMATCH_OUT(VARIANT_MISMATCH_OUT));

// *** verification/spd_serial_source.sv ***
// Purpose: serial bit source feeding the detector pins
// Assumes: driven from the reference clock, one bit per call
// Notes: extra stretches both clock phases for a slow source
`timescale 1ns/10ps
module spd_serial_source (
  input wire logic clk_in,
  output logic serial_clk_out,
  output logic serial_bit_out
);
  initial begin
    serial_clk_out = 1'b0;
    serial_bit_out = 1'b0;
  end
  // clock stands low between bits; bit valid 3 cycles around the rising edge
  task automatic send_bit(input logic b, input int extra);
    @(posedge clk_in);
    #1 serial_bit_out = b;
    repeat (3) @(posedge clk_in);
    #1 serial_clk_out = 1'b1;
    repeat (3 + extra) @(posedge clk_in);
    #1 serial_clk_out = 1'b0;
    serial_bit_out = ~b; // hold time over, line no longer shows the bit
    repeat (4 + extra) @(posedge clk_in);
  endtask
endmodule // spd_serial_source

// *** verification/testbench.sv ***
// Purpose: self-checking bench of the serial 101 pattern detector
// Assumes: source model paces every bit, no open-ended waits
// Notes: expected states worked out by hand from the transition table
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clear = 1'b0;
  wire ser_clk;
  wire ser_bit;
  wire match;
  wire [1:0] state;
  wire [1:0] eng_state;
  wire eng_match;
  wire mism;
  wire [15:0] count;
  wire strobe;
  wire mstart;
  int bad_count = 0;
  int samples_checked = 0;
  int strobe_seen = 0;
  int start_seen = 0;
  always #4 ref_clk = ~ref_clk;
  // pulses counted away from the rising edge
  always @(negedge ref_clk) begin
    if (strobe === 1'b1) strobe_seen++;
    if (mstart === 1'b1) start_seen++;
  end
  spd_serial_source i_spd_serial_source (.clk_in(ref_clk), .serial_clk_out(ser_clk),
    .serial_bit_out(ser_bit));
  spd_pattern_detector i_spd_pattern_detector (.REF_CLK_IN(ref_clk), .RESET_N_IN(rst_n),
    .SERIAL_CLK_IN(ser_clk), .SERIAL_BIT_IN(ser_bit), .SYNC_CLEAR_IN(clear),
    .MATCH_OUT(match), .STATE_OUT(state), .MATCH_START_OUT(mstart),
    .SAMPLE_STROBE_OUT(strobe),
    .MATCH_COUNT_OUT(count), .ENGINE_MATCH_OUT(eng_match),
    .ENGINE_STATE_OUT(eng_state), .VARIANT_MISMATCH_OUT(mism));
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_state(input logic [1:0] exp);
    samples_checked++;
    if (state !== exp || match !== &exp || eng_state !== exp || eng_match !== &exp ||
        mism !== 1'b0) begin
      bad_count++;
      $display("BAD %0t state %b expected %b", $time, state, exp);
    end
  endtask
  task automatic chk_count(input logic [15:0] exp);
    samples_checked++;
    if (count !== exp) begin
      bad_count++;
      $display("BAD %0t count %h expected %h", $time, count, exp);
    end
  endtask
  task automatic chk_pulses(input int exp_strobe, input int exp_start);
    samples_checked++;
    if (strobe_seen != exp_strobe || start_seen != exp_start) begin
      bad_count++;
      $display("BAD %0t pulses %0d %0d expected %0d %0d", $time, strobe_seen, start_seen,
        exp_strobe, exp_start);
    end
  endtask
  task automatic send_chk(input logic b, input logic [1:0] exp, input int extra);
    i_spd_serial_source.send_bit(b, extra);
    chk_state(exp);
  endtask
  task automatic sc_pattern;
    send_chk(1'b0, 2'h0, 0);
    send_chk(1'b1, 2'h1, 0);
    send_chk(1'b0, 2'h2, 0);
    send_chk(1'b1, 2'h3, 0);
    send_chk(1'b1, 2'h3, 0);
    send_chk(1'b0, 2'h0, 0);
    chk_count(16'h0001);
    chk_pulses(6, 1);
  endtask
  task automatic sc_mismatch;
    send_chk(1'b1, 2'h1, 0);
    send_chk(1'b1, 2'h1, 0);
    send_chk(1'b0, 2'h2, 0);
    send_chk(1'b0, 2'h0, 0);
    chk_count(16'h0001);
    chk_pulses(10, 1);
  endtask
  task automatic sc_slow;
    send_chk(1'b1, 2'h1, 2);
    send_chk(1'b1, 2'h1, 2);
    send_chk(1'b1, 2'h1, 2);
    send_chk(1'b0, 2'h2, 2);
    send_chk(1'b1, 2'h3, 2);
    chk_count(16'h0002);
    chk_pulses(15, 2);
  endtask
  task automatic sc_clear;
    @(posedge ref_clk);
    #1 clear = 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_state(2'h0);
    chk_count(16'h0000);
    #1 clear = 1'b0;
    repeat (4) @(posedge ref_clk);
    send_chk(1'b1, 2'h1, 0);
    chk_pulses(16, 2);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_state(2'h0);
    chk_pulses(0, 0);
    sc_pattern();
    sc_mismatch();
    sc_slow();
    sc_clear();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    $display("BAD %0t run did not finish in time", $time);
    complete_run();
  end
endmodule // testbench
